/* hdl/psei_events.sv */
// power supply event flags, enables, rail source tracking and the shared interrupt
// What this block does
// RL1: switch from main to battery sets the switchover flag; enable bit 1 routes it.
// RL2: return from battery to main sets the restore flag; enable bit 7 routes it.
// RL3: switchover and restore flags set even when their enables are clear.
// RL4: these flags stay until software writes zero; writing one keeps them.
// RL5: peripheral config bit 6 reads one on main supply, zero on battery.
// RL6: sense reading change beyond the delta threshold sets the sense adc flag.
// RL7: enable bit 3 routes the sense adc event to the interrupt.
// RL8: periodic background conversions plus one per adc start write, each marked ready.
// RL9: battery flag sets on reading below threshold or on a new reading.
// RL10: enable bit 2 routes the battery event to the interrupt.
// RL11: flag bit 0 sets when the sense comparator reports below 1.2 V.
// RL12: enable bit 0 routes the sense comparator event to the interrupt.
// RL13: dip flag sets when line stays below level for the programmed cycles.
// RL14: enable bit 5 routes the line dip event to the interrupt.
// RL15: sense low flag rises no sooner than 10 ns after the drop.
// RL16: switch to battery no sooner than 10 ns after main drops low.
// RL17: with sense cause selected, switchover follows a low sense after about 30 ms.
// RL18: return to main about 130 ms after restore conditions hold, per selector.
// RL19: interrupt reaches the core only with global enable set, clear after reset.
// RL20: selector 0b01 picks low sense as cause, 0b00 low main supply.
// RL21: interrupt asserts while any flag is set with its enable.
module psei_events
    import psei_pkg::*;
#(
    parameter int unsigned SENSE_SWITCH_CYCLES = CYC_SENSE_SWITCH,
    parameter int unsigned RESTORE_CYCLES      = CYC_RESTORE,
    parameter int unsigned ADC_PERIOD_CYCLES   = CYC_ADC_PERIOD
)
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire psei_sfr_req_type sfr_req,
    output logic      [7:0]       sfr_rdata,
    input  wire psei_analog_type  analog,
    output logic                  adc_convert,
    output logic                  rail_use_battery,
    output logic                  power_irq
);

    // =====================================================
    // input synchronisers
    logic [3:0] levels_sync;

    psei_sync #(.WIDTH(4)) u_sync
    (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({analog.main_low, analog.sense_low, analog.line_below, analog.line_cycle}),
        .sync_out (levels_sync)
    );

    wire main_low_s   = levels_sync[3];
    wire sense_low_s  = levels_sync[2];
    wire line_below_s = levels_sync[1];
    wire line_cycle_s = levels_sync[0];

    // =====================================================
    // registers
    logic [7:0]    power_irq_enable;
    logic [7:0]    power_irq_flags;
    logic [7:0]    supply_delta_threshold;
    logic [7:0]    battery_low_threshold;
    logic [7:0]    battery_reading;
    logic [7:0]    sense_reading;
    logic [7:0]    line_dip_level;
    logic [7:0]    line_dip_cycles;
    logic [7:0]    adc_start;
    logic [1:0]    switchover_cause_select;
    logic          power_irq_global_en;
    psei_rail_type rail_state;
    logic [31:0]   rail_timer;
    logic [31:0]   adc_timer;
    logic [7:0]    dip_count;
    logic          line_cycle_d;
    logic          sense_low_d;
    logic          bat_valid_m;
    logic          bat_valid_d;
    logic          bat_valid_s;
    logic          sense_valid_m;
    logic          sense_valid_d;
    logic          sense_valid_s;

    wire wr_en      = sfr_req.wr && (sfr_req.addr == ADDR_IRQ_ENABLE);
    wire wr_flags   = sfr_req.wr && (sfr_req.addr == ADDR_IRQ_FLAGS);
    wire wr_delta   = sfr_req.wr && (sfr_req.addr == ADDR_DELTA_THRESHOLD);
    wire wr_bthr    = sfr_req.wr && (sfr_req.addr == ADDR_BATTERY_THRESH);
    wire wr_dlvl    = sfr_req.wr && (sfr_req.addr == ADDR_LINE_DIP_LEVEL);
    wire wr_dcyc    = sfr_req.wr && (sfr_req.addr == ADDR_LINE_DIP_CYCLES);
    wire wr_start   = sfr_req.wr && (sfr_req.addr == ADDR_ADC_START);
    wire wr_switch  = sfr_req.wr && (sfr_req.addr == ADDR_SWITCH_CONFIG);
    wire wr_en2     = sfr_req.wr && (sfr_req.addr == ADDR_IRQ_ENABLE2);

    // =====================================================
    // rail source machine
    wire rail_is_main = (rail_state == RAIL_MAIN) || (rail_state == RAIL_LEAVING);
    wire cause_sense  = (switchover_cause_select == CAUSE_SENSE); // RL20
    wire leave_cond   = main_low_s || (cause_sense && sense_low_s);
    wire restore_ok   = !main_low_s && !(cause_sense && sense_low_s); // RL18
    wire leave_now    = main_low_s || (rail_timer >= SENSE_SWITCH_CYCLES - 1); // RL16 RL17
    wire to_battery   = (rail_state == RAIL_LEAVING) && leave_now;
    wire to_main      = (rail_state == RAIL_RETURNING) && restore_ok
                        && (rail_timer >= RESTORE_CYCLES - 1); // RL18

    psei_rail_type next_rail_state;

    always_comb
    begin
        next_rail_state = rail_state;
        case (rail_state)
            RAIL_MAIN:
                if (leave_cond) next_rail_state = RAIL_LEAVING;
            RAIL_LEAVING:
                if (to_battery) next_rail_state = RAIL_BATTERY;
                else if (!leave_cond) next_rail_state = RAIL_MAIN;
            RAIL_BATTERY:
                if (restore_ok) next_rail_state = RAIL_RETURNING;
            RAIL_RETURNING:
                if (to_main) next_rail_state = RAIL_MAIN;
                else if (!restore_ok) next_rail_state = RAIL_BATTERY;
            default:
                next_rail_state = RAIL_MAIN;
        endcase
    end

    wire [31:0] next_rail_timer = (next_rail_state != rail_state) ? 32'h0 : 32'(rail_timer + 1);

    // =====================================================
    // event detection
    wire sense_low_rise = sense_low_s && !sense_low_d; // RL11 RL15
    wire dip_hit        = line_below_s && line_cycle_s && !line_cycle_d
                          && (dip_count == 8'(line_dip_cycles - 8'h01)) && (line_dip_cycles != 8'h00); // RL13
    wire bat_new        = bat_valid_s && !bat_valid_d;
    wire bat_event      = bat_new || (bat_new && (analog.bat_value < battery_low_threshold)); // RL9
    wire sense_new      = sense_valid_s && !sense_valid_d; // RL8
    wire sense_event    = sense_new && (abs_diff(analog.sense_value, sense_reading) > supply_delta_threshold); // RL6
    wire adc_tick       = (adc_timer >= ADC_PERIOD_CYCLES - 1);

    logic [7:0] set_bits;
    always_comb
    begin
        set_bits                 = 8'h00;
        set_bits[BIT_SWITCHOVER] = to_battery; // RL1 RL3
        set_bits[BIT_RESTORE]    = to_main; // RL2 RL3
        set_bits[BIT_SENSE_LOW]  = sense_low_rise;
        set_bits[BIT_BATTERY]    = bat_event;
        set_bits[BIT_SENSE_ADC]  = sense_event;
        set_bits[BIT_LINE_DIP]   = dip_hit;
    end

    // set wins over a software clear in the same cycle
    wire [7:0] kept_bits = wr_flags ? (power_irq_flags & sfr_req.wdata) : power_irq_flags; // RL4
    wire [7:0] next_flags = (kept_bits | set_bits) & FLAG_MASK;
    // next enables too, so a write to either enable register moves the request with it
    wire [7:0] next_enable = wr_en ? sfr_req.wdata : power_irq_enable;
    wire next_global = wr_en2 ? sfr_req.wdata[BIT_GLOBAL_EN] : power_irq_global_en;
    wire next_irq = next_global && |(next_flags & next_enable); // RL21 RL19 RL7 RL10 RL12 RL14

    // =====================================================
    // sequential state
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rail_state <= RAIL_MAIN;
            rail_timer <= 32'h0;
        end
        else
        begin
            rail_state <= next_rail_state;
            rail_timer <= next_rail_timer;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            power_irq_flags <= RESET_BYTE;
            power_irq       <= 1'b0;
            sense_low_d     <= 1'b0;
            line_cycle_d    <= 1'b0;
            bat_valid_m     <= 1'b0;
            bat_valid_s     <= 1'b0;
            bat_valid_d     <= 1'b0;
            sense_valid_m   <= 1'b0;
            sense_valid_s   <= 1'b0;
            sense_valid_d   <= 1'b0;
        end
        else
        begin
            power_irq_flags <= next_flags;
            power_irq       <= next_irq;
            sense_low_d     <= sense_low_s;
            line_cycle_d    <= line_cycle_s;
            // two flops before the edge detect; only the second reads the first
            bat_valid_m     <= analog.bat_valid;
            bat_valid_s     <= bat_valid_m;
            bat_valid_d     <= bat_valid_s;
            sense_valid_m   <= analog.sense_valid;
            sense_valid_s   <= sense_valid_m;
            sense_valid_d   <= sense_valid_s;
        end
    end

    // readings: data held stable by the converter while its valid stays high
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            battery_reading <= RESET_BYTE;
            sense_reading   <= RESET_BYTE;
        end
        else
        begin
            if (bat_new)
                battery_reading <= analog.bat_value;
            if (sense_new)
                sense_reading <= analog.sense_value;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            dip_count <= 8'h00;
        else if (!line_below_s || dip_hit)
            dip_count <= 8'h00;
        else if (line_cycle_s && !line_cycle_d)
            dip_count <= 8'(dip_count + 8'h01); // RL13
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            adc_timer   <= 32'h0;
            adc_convert <= 1'b0;
        end
        else
        begin
            adc_timer   <= (adc_tick || wr_start) ? 32'h0 : 32'(adc_timer + 1);
            adc_convert <= adc_tick || wr_start; // RL8
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rail_use_battery <= 1'b0;
        else
            rail_use_battery <= !rail_is_main;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            power_irq_enable        <= RESET_BYTE;
            supply_delta_threshold  <= RESET_BYTE;
            battery_low_threshold   <= RESET_BYTE;
            line_dip_level          <= RESET_BYTE;
            line_dip_cycles         <= RESET_BYTE;
            adc_start               <= RESET_BYTE;
            switchover_cause_select <= CAUSE_MAIN;
            power_irq_global_en     <= 1'b0; // RL19
        end
        else
        begin
            if (wr_en)     power_irq_enable        <= sfr_req.wdata;
            if (wr_delta)  supply_delta_threshold  <= sfr_req.wdata;
            if (wr_bthr)   battery_low_threshold   <= sfr_req.wdata;
            if (wr_dlvl)   line_dip_level          <= sfr_req.wdata;
            if (wr_dcyc)   line_dip_cycles         <= sfr_req.wdata;
            if (wr_start)  adc_start               <= sfr_req.wdata;
            if (wr_switch) switchover_cause_select <= sfr_req.wdata[1:0];
            if (wr_en2)    power_irq_global_en     <= sfr_req.wdata[BIT_GLOBAL_EN];
        end
    end

    // =====================================================
    // read mux
    wire [7:0] peripheral_config_rd = rail_is_main ? RESET_PERIPHERAL_CONFIG : RESET_BYTE; // RL5
    logic [7:0] next_rdata;
    always_comb
    begin
        if (sfr_req.addr == ADDR_IRQ_FLAGS)            next_rdata = power_irq_flags;
        else if (sfr_req.addr == ADDR_IRQ_ENABLE)      next_rdata = power_irq_enable;
        else if (sfr_req.addr == ADDR_PERIPHERAL_CONFIG_CONFIG)   next_rdata = peripheral_config_rd;
        else if (sfr_req.addr == ADDR_DELTA_THRESHOLD) next_rdata = supply_delta_threshold;
        else if (sfr_req.addr == ADDR_BATTERY_THRESH)  next_rdata = battery_low_threshold;
        else if (sfr_req.addr == ADDR_BATTERY_READING) next_rdata = battery_reading;
        else if (sfr_req.addr == ADDR_SENSE_READING)   next_rdata = sense_reading;
        else if (sfr_req.addr == ADDR_LINE_DIP_LEVEL)  next_rdata = line_dip_level;
        else if (sfr_req.addr == ADDR_LINE_DIP_CYCLES) next_rdata = line_dip_cycles;
        else if (sfr_req.addr == ADDR_ADC_START)       next_rdata = adc_start;
        else if (sfr_req.addr == ADDR_SWITCH_CONFIG)   next_rdata = {6'h00, switchover_cause_select};
        else if (sfr_req.addr == ADDR_IRQ_ENABLE2)     next_rdata = {6'h00, power_irq_global_en, 1'b0};
        else                                           next_rdata = RESET_BYTE;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            sfr_rdata <= RESET_BYTE;
        else
            sfr_rdata <= next_rdata;
    end

    // =====================================================
    // checks
    a_irq_follows_flags: assert property (@(posedge sys_clk) disable iff (rst)
        power_irq == (power_irq_global_en && |(power_irq_flags & power_irq_enable)))
        else $error("interrupt does not match flags and enables"); // RL21

    a_switch_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
        to_battery |=> power_irq_flags[BIT_SWITCHOVER]) else $error("switchover flag missing"); // RL1

    a_restore_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
        to_main |=> power_irq_flags[BIT_RESTORE]) else $error("restore flag missing"); // RL2

    a_write_one_keeps: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_flags && power_irq_flags[BIT_SWITCHOVER] && sfr_req.wdata[BIT_SWITCHOVER])
        |=> power_irq_flags[BIT_SWITCHOVER]) else $error("flag lost on write of one"); // RL4

    a_write_zero_clears: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_flags && !sfr_req.wdata[BIT_RESTORE] && !to_main) |=> !power_irq_flags[BIT_RESTORE])
        else $error("restore flag not cleared"); // RL4

    a_global_gate: assert property (@(posedge sys_clk) disable iff (rst)
        !power_irq_global_en |=> !power_irq || $past(wr_en2)) else $error("interrupt without global enable"); // RL19

    a_rail_bit_track: assert property (@(posedge sys_clk) disable iff (rst)
        rail_use_battery == !$past(rail_is_main)) else $error("rail source bit wrong"); // RL5

    a_start_converts: assert property (@(posedge sys_clk) disable iff (rst)
        wr_start |=> adc_convert) else $error("adc start ignored"); // RL8

    a_sense_low_delay: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(power_irq_flags[BIT_SENSE_LOW]) |-> $past(sense_low_s)) else $error("sense flag too early"); // RL15

    a_battery_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
        bat_new |=> power_irq_flags[BIT_BATTERY]) else $error("battery flag missing"); // RL9

    a_dip_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
        dip_hit |=> power_irq_flags[BIT_LINE_DIP]) else $error("line dip flag missing"); // RL13

    c_switchover: cover property (@(posedge sys_clk) disable iff (rst) to_battery);
    c_restore:    cover property (@(posedge sys_clk) disable iff (rst) to_main);
    c_irq:        cover property (@(posedge sys_clk) disable iff (rst) $rose(power_irq));
    c_line_dip:   cover property (@(posedge sys_clk) disable iff (rst) dip_hit);
    c_battery:    cover property (@(posedge sys_clk) disable iff (rst) bat_event);

endmodule : psei_events

/* hdl/psei_pkg.sv */
// package: register map, field positions, reset values and timing counts for power supply events
package psei_pkg;

    localparam int unsigned CLK_HZ = 40000000;

    // register addresses on the special-function bus
    localparam logic [7:0] ADDR_LINE_DIP_CYCLES  = 8'h13;
    localparam logic [7:0] ADDR_LINE_DIP_LEVEL   = 8'h14;
    localparam logic [7:0] ADDR_ADC_START        = 8'hD8;
    localparam logic [7:0] ADDR_BATTERY_READING  = 8'hDF;
    localparam logic [7:0] ADDR_IRQ_ENABLE       = 8'hEC;
    localparam logic [7:0] ADDR_DELTA_THRESHOLD  = 8'hF3;
    localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_CONFIG    = 8'hF4;
    localparam logic [7:0] ADDR_SWITCH_CONFIG    = 8'hF5;
    localparam logic [7:0] ADDR_IRQ_FLAGS        = 8'hF8;
    localparam logic [7:0] ADDR_BATTERY_THRESH   = 8'hFA;
    localparam logic [7:0] ADDR_SENSE_READING    = 8'hEF;
    localparam logic [7:0] ADDR_IRQ_ENABLE2      = 8'hA9;

    // flag, enable and rail status bit positions
    localparam int unsigned BIT_SENSE_LOW  = 0;
    localparam int unsigned BIT_SWITCHOVER = 1;
    localparam int unsigned BIT_BATTERY    = 2;
    localparam int unsigned BIT_SENSE_ADC  = 3;
    localparam int unsigned BIT_LINE_DIP   = 5;
    localparam int unsigned BIT_RESTORE    = 7;
    localparam int unsigned BIT_RAIL_MAIN  = 6;
    localparam int unsigned BIT_GLOBAL_EN  = 1;

    localparam logic [7:0] FLAG_MASK       = 8'hAF;
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam logic [7:0] RESET_PERIPHERAL_CONFIG    = 8'h40;

    localparam logic [1:0] CAUSE_SENSE     = 2'h1;
    localparam logic [1:0] CAUSE_MAIN      = 2'h0;

    // timing, figures in their own units
    localparam int unsigned T_SENSE_FLAG_NS  = 10;
    localparam int unsigned T_MAIN_SWITCH_NS = 10;
    localparam int unsigned T_SENSE_SWITCH_MS = 30;
    localparam int unsigned T_RESTORE_MS     = 130;
    localparam int unsigned PERIOD_NS        = 1000000000 / CLK_HZ;
    localparam int unsigned CYC_SENSE_FLAG   = (T_SENSE_FLAG_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int unsigned CYC_MAIN_SWITCH  = (T_MAIN_SWITCH_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int unsigned CYC_SENSE_SWITCH = T_SENSE_SWITCH_MS * (CLK_HZ / 1000);
    localparam int unsigned CYC_RESTORE      = T_RESTORE_MS * (CLK_HZ / 1000);
    localparam int unsigned CYC_ADC_PERIOD   = 4000;

    typedef enum logic [1:0]
    {
        RAIL_MAIN      = 2'b00,
        RAIL_LEAVING   = 2'b01,
        RAIL_BATTERY   = 2'b11,
        RAIL_RETURNING = 2'b10
    } psei_rail_type;

    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } psei_sfr_req_type;

    typedef struct packed
    {
        logic main_low;
        logic sense_low;
        logic line_below;
        logic line_cycle;
        logic bat_valid;
        logic [7:0] bat_value;
        logic sense_valid;
        logic [7:0] sense_value;
    } psei_analog_type;

    function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? 8'(a - b) : 8'(b - a);
    endfunction : abs_diff

endpackage : psei_pkg

/* hdl/psei_sync.sv */
// two-flop synchroniser bank for the analog status levels
module psei_sync
    import psei_pkg::*;
#(
    parameter int unsigned WIDTH = 4
)
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : psei_sync

/* sim/psei_events_tb.sv */
// testbench: register access, event flags, rail switchover and the shared interrupt
module psei_events_tb
    import psei_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // shortened counts so the run stays brief
    localparam int unsigned SW = 20;
    localparam int unsigned RS = 30;
    localparam int unsigned AP = 50;

    logic             sys_clk;
    logic             rst;
    psei_sfr_req_type sfr_req;
    psei_analog_type  analog;
    logic [7:0]       sfr_rdata;
    logic             adc_convert;
    logic             rail_use_battery;
    logic             power_irq;
    int               n_mismatch;
    int               n_tests;
    int               pulses;
    int               p0;

    psei_events #(
        .SENSE_SWITCH_CYCLES (SW),
        .RESTORE_CYCLES      (RS),
        .ADC_PERIOD_CYCLES   (AP)
    ) u_dut (
        .sys_clk          (sys_clk),
        .rst              (rst),
        .sfr_req          (sfr_req),
        .sfr_rdata        (sfr_rdata),
        .analog           (analog),
        .adc_convert      (adc_convert),
        .rail_use_battery (rail_use_battery),
        .power_irq        (power_irq)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // counted away from the edge that launches the pulse
    always @(negedge sys_clk)
    begin
        if (adc_convert === 1'b1)
            pulses++;
    end

    // ==========================================================
    // tasks
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    // extra edge at the end so back-to-back writes never retoggle the strobe in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req.addr = a;
        sfr_req.wdata = d;
        sfr_req.wr = 1'b1;
        @(negedge sys_clk);
        sfr_req.wr = 1'b0;
        @(negedge sys_clk);
    endtask : wr

    // read data is registered, so look one edge after the address goes out
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m, input string what);
        sfr_req.addr = a;
        @(negedge sys_clk);
        chk(sfr_rdata & m, exp, what);
    endtask : rd

    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk({7'h00, got}, {7'h00, exp}, what);
    endtask : chk_bit

    // flag latched with enables clear, then gated, routed, masked and cleared
    task automatic route(input int b);
        logic [7:0] m;
        m = 8'h01 << b;
        rd(ADDR_IRQ_FLAGS, m, m, "flag set");
        wr(ADDR_IRQ_FLAGS, 8'hFF);
        rd(ADDR_IRQ_FLAGS, m, m, "flag kept on one");
        wr(ADDR_IRQ_ENABLE, m);
        cyc(2);
        chk_bit(power_irq, 1'b0, "irq without global");
        wr(ADDR_IRQ_ENABLE2, 8'h02);
        cyc(2);
        chk_bit(power_irq, 1'b1, "irq routed");
        wr(ADDR_IRQ_ENABLE, 8'h00);
        cyc(2);
        chk_bit(power_irq, 1'b0, "irq masked");
        wr(ADDR_IRQ_ENABLE2, 8'h00);
        wr(ADDR_IRQ_FLAGS, ~m);
        rd(ADDR_IRQ_FLAGS, 8'h00, m, "flag cleared");
    endtask : route

    task automatic sense(input logic [7:0] v);
        analog.sense_value = v;
        analog.sense_valid = 1'b1;
        cyc(6);
        analog.sense_valid = 1'b0;
        cyc(2);
    endtask : sense

    task automatic line_tick;
        analog.line_cycle = 1'b1;
        cyc(4);
        analog.line_cycle = 1'b0;
        cyc(4);
    endtask : line_tick

    // ==========================================================
    // watchdog, far beyond the expected run of some 650 cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        $display("ERROR t=%0t watchdog expired", $time);
        print_verdict();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        sfr_req = '0;
        analog = '0;
        rst = 1'b1;
        n_mismatch = 0;
        n_tests = 0;
        pulses = 0;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        rd(ADDR_IRQ_FLAGS, 8'h00, 8'hFF, "flags at reset");
        rd(ADDR_IRQ_ENABLE, 8'h00, 8'hFF, "enables at reset");
        rd(ADDR_IRQ_ENABLE2, 8'h00, 8'h02, "global at reset");
        rd(ADDR_PERIPHERAL_CONFIG_CONFIG, 8'h40, 8'h40, "rail main at reset");
        wr(8'h55, 8'hA5);
        rd(8'h55, 8'h00, 8'hFF, "unmapped reads zero");
        wr(ADDR_LINE_DIP_LEVEL, 8'h5A);
        rd(ADDR_LINE_DIP_LEVEL, 8'h5A, 8'hFF, "dip level stored");
        wr(ADDR_BATTERY_THRESH, 8'hA5);
        rd(ADDR_BATTERY_THRESH, 8'hA5, 8'hFF, "bat thresh stored");
        // battery reading: new value flags the event, register is read only
        analog.bat_value = 8'h5A;
        analog.bat_valid = 1'b1;
        cyc(6);
        analog.bat_valid = 1'b0;
        cyc(2);
        wr(ADDR_BATTERY_READING, 8'h00);
        rd(ADDR_BATTERY_READING, 8'h5A, 8'hFF, "bat reading");
        route(BIT_BATTERY);
        // sense adc delta: equal to threshold is not a change, one above is
        wr(ADDR_DELTA_THRESHOLD, 8'h10);
        rd(ADDR_DELTA_THRESHOLD, 8'h10, 8'hFF, "delta stored");
        sense(8'h80);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        sense(8'h90);
        rd(ADDR_IRQ_FLAGS, 8'h00, 8'h08, "delta at limit");
        sense(8'hA1);
        route(BIT_SENSE_ADC);
        // comparator low with main cause selected: flag only, rail stays on main
        analog.sense_low = 1'b1;
        cyc(SW + 10);
        chk_bit(rail_use_battery, 1'b0, "no switch on sense");
        analog.sense_low = 1'b0;
        cyc(4);
        route(BIT_SENSE_LOW);
        // line dip needs the full programmed count of cycles
        wr(ADDR_LINE_DIP_CYCLES, 8'h03);
        rd(ADDR_LINE_DIP_CYCLES, 8'h03, 8'hFF, "dip cycles");
        analog.line_below = 1'b1;
        line_tick();
        line_tick();
        rd(ADDR_IRQ_FLAGS, 8'h00, 8'h20, "dip too short");
        line_tick();
        analog.line_below = 1'b0;
        cyc(2);
        route(BIT_LINE_DIP);
        // main supply low: switchover, then restore after the long delay
        analog.main_low = 1'b1;
        cyc(1);
        chk_bit(rail_use_battery, 1'b0, "switch not instant");
        cyc(9);
        chk_bit(rail_use_battery, 1'b1, "on battery");
        rd(ADDR_PERIPHERAL_CONFIG_CONFIG, 8'h00, 8'h40, "rail bit battery");
        route(BIT_SWITCHOVER);
        analog.main_low = 1'b0;
        cyc(RS - 5);
        chk_bit(rail_use_battery, 1'b1, "restore waits");
        cyc(20);
        chk_bit(rail_use_battery, 1'b0, "back on main");
        rd(ADDR_PERIPHERAL_CONFIG_CONFIG, 8'h40, 8'h40, "rail bit main");
        route(BIT_RESTORE);
        // sense cause: delayed switch, and restore needs the sense level back too
        wr(ADDR_SWITCH_CONFIG, 8'h01);
        analog.sense_low = 1'b1;
        cyc(SW - 5);
        chk_bit(rail_use_battery, 1'b0, "sense switch waits");
        cyc(20);
        chk_bit(rail_use_battery, 1'b1, "sense switch");
        cyc(RS + 20);
        chk_bit(rail_use_battery, 1'b1, "held while sense low");
        analog.sense_low = 1'b0;
        cyc(RS + 20);
        chk_bit(rail_use_battery, 1'b0, "sense restore");
        // conversions: background period and one on a start write
        p0 = pulses;
        cyc(4 * AP);
        chk_bit((pulses - p0) >= 3 && (pulses - p0) <= 5, 1'b1, "periodic adc");
        p0 = pulses;
        wr(ADDR_ADC_START, 8'h01);
        cyc(3);
        chk_bit(pulses > p0, 1'b1, "adc on start write");
        print_verdict();
    end

endmodule : psei_events_tb
